// ### common/usart_sfd_pkg.sv
package usart_sfd_pkg;
	// Byte offsets of the printed map; not all are multiples of four,
	// so each is a register index and the AHB byte address is four times it.
	localparam logic [7:0] IDX_BAUD_LOW_CH0 = 8'h21;
	localparam logic [7:0] IDX_BAUD_HIGH_CH0 = 8'h22;
	localparam logic [7:0] IDX_START_DET_CH0 = 8'h23;
	localparam logic [7:0] IDX_BAUD_LOW_CH1 = 8'h74;
	localparam logic [7:0] IDX_BAUD_HIGH_CH1 = 8'h75;
	localparam logic [7:0] IDX_START_DET_CH1 = 8'h76;
	// Own registers: mode/control per channel
	localparam logic [7:0] IDX_MODE_CTRL_CH0 = 8'h24;
	localparam logic [7:0] IDX_MODE_CTRL_CH1 = 8'h77;
	// Start detect control fields
	localparam int RX_START_IRQ_ENABLE_BIT = 7;
	localparam int RX_START_FLAG_BIT = 6;
	localparam int START_FRAME_DETECT_ENABLE_BIT = 5;
	localparam logic [7:0] START_DET_RESET = 8'h20;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	// Mode control fields
	localparam int MODE_SELECT_HI_BIT = 7;
	localparam int MODE_SELECT_LO_BIT = 6;
	localparam int CLOCK_PHASE_BIT = 2;
	localparam int RECEIVE_COMPLETE_IRQ_ENABLE_BIT = 1;
	localparam int SYNC_CLOCK_POLARITY_BIT = 0;
	localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
	localparam int BAUD_WIDTH = 12;
	localparam logic [1:0] MODE_ASYNC = 2'h0;
	localparam logic [1:0] MODE_SYNC = 2'h1;
	localparam logic [1:0] MODE_MASTER_SPI = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### verilog/usart_sfd.sv
// Contract
// - Polarity 0: data changes on rising clock edge, sampled falling; 1 swaps.
// - Start flag bit 6 sets on start condition; clears only by writing one.
// - Start interrupt only when its enable, global enable and flag set.
// - Detect enable bit 5 makes high-to-low receive edge a wake-capable start.
// - Detector off when disabled; enables pick which flag wakes; both-clear reserved.
// - With detector and global enable, start interrupt wakes from every sleep.
// - Bits 4:0 of start detect control read zero.
// - Baud setting is 12 bits: high register four MSBs, low eight LSBs.
// - Writing low baud byte immediately reloads the prescaler.
// - Both mode bits one selects master SPI, reusing shifter and baud generator.
// - Master SPI disables parity, recovery and split control; one transfer control.
// - Master SPI keeps pins, interrupts and register addresses unchanged.
// - Master SPI uses internal clock only; software sets clock pin output.
// - Synchronous master bit rate is clock over two times setting plus one.
// - Highest master SPI clock is half the system clock.
// - Master SPI offers bit order, four clock modes, queued transmission.
// - Mode 00 async, 01 sync, 11 master SPI, 10 reserved.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module usart_sfd
	import usart_sfd_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Core status
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic [CHANNELS-1:0] RECEIVE_COMPLETE_FLAG,
	// Serial pins
	input wire logic [CHANNELS-1:0] SERIAL_RECEIVE_PIN,
	output logic [CHANNELS-1:0] SERIAL_CLOCK_OUT,
	input wire logic [CHANNELS-1:0] SERIAL_CLOCK_PIN_DIRECTION,
	output logic [CHANNELS-1:0] SERIAL_CLOCK_OE,
	// Per channel results
	output logic [CHANNELS-1:0] RX_START_IRQ,
	output logic [CHANNELS-1:0] WAKE_REQUEST,
	output logic [CHANNELS-1:0] MASTER_SPI_MODE,
	output logic [CHANNELS-1:0] SYNC_MODE,
	output logic [CHANNELS-1:0] TX_CHANGE_STROBE,
	output logic [CHANNELS-1:0] RX_SAMPLE_STROBE
);
	logic wr_pend;
	logic rd_pend;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic [31:0] next_rdata;
	logic [7:0] start_ctrl [CHANNELS];
	logic [7:0] mode_ctrl [CHANNELS];
	logic [BAUD_WIDTH-1:0] baud [CHANNELS];
	logic [CHANNELS-1:0] start_seen;

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// Address phase capture; zero-wait slave
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_idx <= 8'h00;
			rd_idx <= 8'h00;
		end else if (HREADY) begin
			wr_pend <= HSEL && HTRANS == HTRANS_NONSEQ && HWRITE;
			rd_pend <= HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE;
			wr_idx <= (HADDR[31:10] == 22'h000000) ? HADDR[9:2] : 8'hFF;
			rd_idx <= (HADDR[31:10] == 22'h000000) ? HADDR[9:2] : 8'hFF;
		end
	end

	function automatic logic [7:0] idx_of(input int ch, input int reg_sel);
		logic [7:0] r;
		r = 8'hFF;
		unique case (reg_sel)
			0: r = (ch == 0) ? IDX_BAUD_LOW_CH0 : IDX_BAUD_LOW_CH1;
			1: r = (ch == 0) ? IDX_BAUD_HIGH_CH0 : IDX_BAUD_HIGH_CH1;
			2: r = (ch == 0) ? IDX_START_DET_CH0 : IDX_START_DET_CH1;
			default: r = (ch == 0) ? IDX_MODE_CTRL_CH0 : IDX_MODE_CTRL_CH1;
		endcase
		return r;
	endfunction

	// Read mux; unmapped reads return zero
	always_comb begin
		next_rdata = 32'h00000000;
		for (int c = 0; c < CHANNELS; c++) begin
			if (rd_idx == idx_of(c, 0))
				next_rdata = {24'h000000, baud[c][7:0]};
			if (rd_idx == idx_of(c, 1))
				next_rdata = {28'h0000000, baud[c][11:8]};
			if (rd_idx == idx_of(c, 2))
				next_rdata = {24'h000000, start_ctrl[c][7:5], 5'h00};
			if (rd_idx == idx_of(c, 3))
				next_rdata = {24'h000000, mode_ctrl[c]};
		end
	end
	assign HRDATA = rd_pend ? next_rdata : 32'h00000000;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic rx_meta;
			logic rx_sync;
			logic rx_prev;
			logic [BAUD_WIDTH-1:0] prescale;
			logic half_tick;
			logic xck;
			logic reload;
			logic sfd_en;
			logic start_ie;
			logic [1:0] mode;
			logic internal_clock;

			assign sfd_en = start_ctrl[g][START_FRAME_DETECT_ENABLE_BIT];
			assign start_ie = start_ctrl[g][RX_START_IRQ_ENABLE_BIT];
			assign mode = {mode_ctrl[g][MODE_SELECT_HI_BIT], mode_ctrl[g][MODE_SELECT_LO_BIT]};
			assign reload = wr_pend && wr_idx == idx_of(g, 0);

			// Two flops before the edge detector reads the pin
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					rx_meta <= 1'b1;
					rx_sync <= 1'b1;
					rx_prev <= 1'b1;
				end else begin
					rx_meta <= SERIAL_RECEIVE_PIN[g];
					rx_sync <= rx_meta;
					rx_prev <= rx_sync;
				end
			end
			assign start_seen[g] = sfd_en && rx_prev && !rx_sync;

			// Register writes; start flag set beats its clear
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					start_ctrl[g] <= START_DET_RESET;
					mode_ctrl[g] <= MODE_CTRL_RESET;
					baud[g] <= {BAUD_WIDTH{1'b0}};
				end else begin
					if (wr_pend && wr_idx == idx_of(g, 0))
						baud[g][7:0] <= HWDATA[7:0];
					if (wr_pend && wr_idx == idx_of(g, 1))
						baud[g][11:8] <= HWDATA[3:0];
					if (wr_pend && wr_idx == idx_of(g, 3))
						mode_ctrl[g] <= HWDATA[7:0];
					if (wr_pend && wr_idx == idx_of(g, 2)) begin
						start_ctrl[g][RX_START_IRQ_ENABLE_BIT] <= HWDATA[RX_START_IRQ_ENABLE_BIT];
						start_ctrl[g][START_FRAME_DETECT_ENABLE_BIT] <=
							HWDATA[START_FRAME_DETECT_ENABLE_BIT];
					end
					if (start_seen[g])
						start_ctrl[g][RX_START_FLAG_BIT] <= 1'b1;
					else if (wr_pend && wr_idx == idx_of(g, 2) && HWDATA[RX_START_FLAG_BIT])
						start_ctrl[g][RX_START_FLAG_BIT] <= 1'b0;
				end
			end

			// Divider runs at 2*(setting+1); low-byte write restarts it
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					prescale <= {BAUD_WIDTH{1'b0}};
					xck <= 1'b0;
				end else if (reload) begin
					prescale <= {baud[g][11:8], HWDATA[7:0]};
					xck <= 1'b0;
				end else if (prescale == {BAUD_WIDTH{1'b0}}) begin
					prescale <= baud[g];
					xck <= !xck;
				end else begin
					prescale <= prescale - 1'b1;
				end
			end
			assign half_tick = !reload && prescale == {BAUD_WIDTH{1'b0}};

			// Sync master and master SPI use the internal clock only
			assign internal_clock = mode == MODE_SYNC || mode == MODE_MASTER_SPI;
			assign SERIAL_CLOCK_OUT[g] = xck ^ mode_ctrl[g][SYNC_CLOCK_POLARITY_BIT];
			assign SERIAL_CLOCK_OE[g] = internal_clock && SERIAL_CLOCK_PIN_DIRECTION[g];
			assign MASTER_SPI_MODE[g] = mode == MODE_MASTER_SPI;
			assign SYNC_MODE[g] = mode == MODE_SYNC;
			// Pin edge about to occur is rising when SERIAL_CLOCK_OUT is low
			// Unshifted clock low means the pin moves to its data-change edge next, except master SPI with phase bit clear, where xck high does
			assign TX_CHANGE_STROBE[g] = internal_clock && half_tick &&
				(xck == (MASTER_SPI_MODE[g] && !mode_ctrl[g][CLOCK_PHASE_BIT]));
			assign RX_SAMPLE_STROBE[g] = internal_clock && half_tick && !TX_CHANGE_STROBE[g];

			// Global enable comes from the core, masking applies here
			assign RX_START_IRQ[g] = start_ie && GLOBAL_IRQ_ENABLE &&
				start_ctrl[g][RX_START_FLAG_BIT];
			assign WAKE_REQUEST[g] = sfd_en && GLOBAL_IRQ_ENABLE &&
				((start_ie && start_ctrl[g][RX_START_FLAG_BIT]) ||
				(mode_ctrl[g][RECEIVE_COMPLETE_IRQ_ENABLE_BIT] &&
				RECEIVE_COMPLETE_FLAG[g]));

			property p_start_sets;
				@(posedge CLK) disable iff (RESET)
				start_seen[g] |=> start_ctrl[g][RX_START_FLAG_BIT];
			endproperty
			a_start_sets: assert property (p_start_sets) else $error("start flag not set");

			property p_flag_sticky;
				@(posedge CLK) disable iff (RESET)
				start_ctrl[g][RX_START_FLAG_BIT] &&
				!(wr_pend && wr_idx == idx_of(g, 2) && HWDATA[RX_START_FLAG_BIT])
				|=> start_ctrl[g][RX_START_FLAG_BIT];
			endproperty
			a_flag_sticky: assert property (p_flag_sticky) else $error("start flag lost");

			property p_irq;
				@(posedge CLK) disable iff (RESET)
				RX_START_IRQ[g] == (start_ie && GLOBAL_IRQ_ENABLE &&
				start_ctrl[g][RX_START_FLAG_BIT]);
			endproperty
			a_irq: assert property (p_irq) else $error("start irq wrong");

			sequence s_fall;
				rx_sync ##1 !rx_sync;
			endsequence
			property p_edge_flag;
				@(posedge CLK) disable iff (RESET)
				sfd_en ##0 s_fall |=> ##1 start_ctrl[g][RX_START_FLAG_BIT];
			endproperty
			a_edge_flag: assert property (p_edge_flag) else $error("edge missed");

			property p_no_detect_off;
				@(posedge CLK) disable iff (RESET)
				!sfd_en |-> !WAKE_REQUEST[g] && !start_seen[g];
			endproperty
			a_no_detect_off: assert property (p_no_detect_off) else $error("detector not off");

			property p_wake_start;
				@(posedge CLK) disable iff (RESET)
				sfd_en && GLOBAL_IRQ_ENABLE && RX_START_IRQ[g] |-> WAKE_REQUEST[g];
			endproperty
			a_wake_start: assert property (p_wake_start) else $error("no wake");

			property p_reload;
				@(posedge CLK) disable iff (RESET)
				reload |=> prescale == baud[g];
			endproperty
			a_reload: assert property (p_reload) else $error("prescaler not reloaded");

			property p_rate;
				@(posedge CLK) disable iff (RESET)
				half_tick && baud[g] == 12'h000 && !$rose(reload) ##1 !reload
				|-> half_tick;
			endproperty
			a_rate: assert property (p_rate) else $error("half rate broken");

			property p_spi_clock;
				@(posedge CLK) disable iff (RESET)
				MASTER_SPI_MODE[g] && SERIAL_CLOCK_PIN_DIRECTION[g] |-> SERIAL_CLOCK_OE[g];
			endproperty
			a_spi_clock: assert property (p_spi_clock) else $error("clock not driven");
		end
	endgenerate

	property p_reserved_zero;
		@(posedge CLK) disable iff (RESET)
		rd_pend && rd_idx == IDX_START_DET_CH0 |-> HRDATA[4:0] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
endmodule
`default_nettype wire

// ### tb/serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer #(
	parameter int LAG = 3
) (
	// Clock and command
	input wire logic clk,
	input wire logic send,
	// Receive line seen by the device
	output logic line
);
	// Lag lets the peer answer promptly or slowly
	logic [7:0] hist = 8'h00;
	always_ff @(posedge clk) begin
		hist <= {hist[6:0], send};
	end
	// Idle high, start bit pulls low
	assign line = ~hist[LAG];
endmodule
`default_nettype wire

// ### tb/usart_sync_baud_start_detect_test.sv
`timescale 1ns/10ps
`default_nettype none
module usart_sync_baud_start_detect_test;
	import usart_sfd_pkg::*;
	logic CLK, RESET, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, GLOBAL_IRQ_ENABLE;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [2:0] HSIZE;
	logic [1:0] HTRANS, RECEIVE_COMPLETE_FLAG, rx_pin, clk_dir, start_cmd;
	logic [1:0] clk_out, clk_oe, irq, wake, spi, sync, tx_s, rx_s;
	int error_cnt, compares, n;
	assign HREADY = HREADYOUT;
	usart_sfd dut (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
		.RECEIVE_COMPLETE_FLAG(RECEIVE_COMPLETE_FLAG), .SERIAL_RECEIVE_PIN(rx_pin),
		.SERIAL_CLOCK_OUT(clk_out), .SERIAL_CLOCK_PIN_DIRECTION(clk_dir), .SERIAL_CLOCK_OE(clk_oe),
		.RX_START_IRQ(irq), .WAKE_REQUEST(wake), .MASTER_SPI_MODE(spi), .SYNC_MODE(sync),
		.TX_CHANGE_STROBE(tx_s), .RX_SAMPLE_STROBE(rx_s));
	serial_peer #(.LAG(1)) peer0 (.clk(CLK), .send(start_cmd[0]), .line(rx_pin[0]));
	serial_peer #(.LAG(5)) peer1 (.clk(CLK), .send(start_cmd[1]), .line(rx_pin[1]));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= HTRANS_NONSEQ;
		HWRITE <= wr;
		HADDR <= {22'h000000, idx, 2'h0};
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= {24'h000000, wd};
		do @(posedge CLK); while (HREADY !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
	endtask
	task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		bus(1'b0, idx, 8'h00, r);
		chk(what, {24'h000000, exp}, r);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge CLK);
		#1;
	endtask
	// Cycles between two rising serial clock edges on channel 0
	task automatic period(output int p);
		logic prev;
		@(posedge clk_out[0]);
		p = 0;
		prev = 1'b1;
		repeat (1100) begin
			@(posedge CLK);
			#1;
			p++;
			if (clk_out[0] === 1'b1 && prev === 1'b0) break;
			prev = clk_out[0];
		end
	endtask
	// Strobe comes a cycle before the pin edge it announces
	task automatic strobe_chk(input string what, input logic use_rx, input logic exp_before);
		logic s;
		int k;
		s = 1'b0;
		k = 0;
		while (s !== 1'b1 && k < 20) begin
			@(posedge CLK);
			#1;
			s = use_rx ? rx_s[0] : tx_s[0];
			k++;
		end
		chk({what, " before"}, {31'h0, exp_before}, {31'h0, clk_out[0]});
		@(posedge CLK);
		#1;
		chk({what, " after"}, {31'h0, !exp_before}, {31'h0, clk_out[0]});
	endtask
	task automatic tally_and_finish;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		RESET = 1'b1;
		{HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
		HSIZE = 3'h2;
		GLOBAL_IRQ_ENABLE = 1'b0;
		RECEIVE_COMPLETE_FLAG = 2'h0;
		clk_dir = 2'h0;
		start_cmd = 2'h0;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		rd("low0", IDX_BAUD_LOW_CH0, 8'h00);
		rd("high1", IDX_BAUD_HIGH_CH1, 8'h00);
		rd("start0", IDX_START_DET_CH0, 8'h20);
		rd("start1", IDX_START_DET_CH1, 8'h20);
		rd("unmapped", 8'h30, 8'h00);
		wr(IDX_START_DET_CH1, 8'hFF);
		rd("start1 wr", IDX_START_DET_CH1, 8'hA0);
		wr(IDX_BAUD_HIGH_CH0, 8'h0F);
		rd("high0", IDX_BAUD_HIGH_CH0, 8'h0F);
		for (int m = 0; m < 4; m++) begin
			wr(IDX_MODE_CTRL_CH0, {m[1:0], 6'h00});
			settle(1);
			chk("sync", {31'h0, m == 1}, {31'h0, sync[0]});
			chk("spi", {31'h0, m == 3}, {31'h0, spi[0]});
		end
		// Prescaler from a low-byte write, high part taken as well
		clk_dir <= 2'h3;
		wr(IDX_MODE_CTRL_CH0, {MODE_SYNC, 6'h00});
		wr(IDX_BAUD_HIGH_CH0, 8'h01);
		wr(IDX_BAUD_LOW_CH0, 8'h00);
		period(n);
		chk("period 256", 514, n);
		wr(IDX_BAUD_HIGH_CH0, 8'h00);
		wr(IDX_BAUD_LOW_CH0, 8'h02);
		period(n);
		chk("period 2", 6, n);
		chk("oe", 32'h1, {31'h0, clk_oe[0]});
		strobe_chk("tx pol0", 1'b0, 1'b0);
		strobe_chk("rx pol0", 1'b1, 1'b1);
		wr(IDX_MODE_CTRL_CH0, 8'h41);
		strobe_chk("tx pol1", 1'b0, 1'b1);
		strobe_chk("rx pol1", 1'b1, 1'b0);
		wr(IDX_MODE_CTRL_CH0, {MODE_MASTER_SPI, 6'h00});
		wr(IDX_BAUD_LOW_CH0, 8'h00);
		period(n);
		chk("period spi", 2, n);
		// Start condition on each channel
		GLOBAL_IRQ_ENABLE <= 1'b1;
		wr(IDX_START_DET_CH0, 8'hA0);
		wr(IDX_START_DET_CH1, 8'hA0);
		start_cmd <= 2'h3;
		settle(12);
		start_cmd <= 2'h0;
		rd("flag0", IDX_START_DET_CH0, 8'hE0);
		rd("flag1", IDX_START_DET_CH1, 8'hE0);
		chk("irq", 32'h3, {30'h0, irq});
		chk("wake", 32'h3, {30'h0, wake});
		wr(IDX_START_DET_CH0, 8'hA0);
		rd("flag kept", IDX_START_DET_CH0, 8'hE0);
		GLOBAL_IRQ_ENABLE <= 1'b0;
		settle(2);
		chk("irq gated", 32'h0, {31'h0, irq[0]});
		GLOBAL_IRQ_ENABLE <= 1'b1;
		wr(IDX_START_DET_CH0, 8'hE0);
		rd("flag clr", IDX_START_DET_CH0, 8'hA0);
		settle(1);
		chk("irq clr", 32'h0, {31'h0, irq[0]});
		// Detector off: no wake; then receive-complete wake
		wr(IDX_START_DET_CH0, 8'h80);
		start_cmd <= 2'h1;
		settle(10);
		start_cmd <= 2'h0;
		chk("wake off", 32'h0, {31'h0, wake[0]});
		wr(IDX_START_DET_CH0, 8'hE0);
		wr(IDX_START_DET_CH0, 8'h20);
		wr(IDX_MODE_CTRL_CH0, 8'h02);
		RECEIVE_COMPLETE_FLAG <= 2'h1;
		settle(3);
		chk("wake rxc", 32'h1, {31'h0, wake[0]});
		tally_and_finish;
	end
endmodule
`default_nettype wire
